// *** hdl/flash_regs_pkg.sv ***
// Purpose: Shared constants and types of the flash status and config bank
// Assumes: 100 MHz core clock; the serial link clock is a separate domain
// Notes: Bit positions refer to the three 8-bit register images
`default_nettype none
package flash_regs_pkg;
  // Core clock rate and register-write busy time
  localparam int SYS_CLK_MHZ = 100;
  localparam int REG_WRITE_TIME_NS = 1000;
  localparam int REG_WRITE_CYCLES_RAW =
    (REG_WRITE_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] REG_WRITE_CYCLES = REG_WRITE_CYCLES_RAW[7:0];

  // Primary status field positions
  localparam int STAT_LOCK_BIT = 7;
  localparam int STAT_PERR_BIT = 6;
  localparam int STAT_EERR_BIT = 5;
  localparam int STAT_BP_LSB = 2;
  localparam int STAT_WEL_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;

  // Device configuration field positions
  localparam int CFG_LAT_LSB = 6;
  localparam int CFG_ORIGIN_BIT = 5;
  localparam int CFG_VOLAT_BIT = 3;
  localparam int CFG_PARAM_BIT = 2;
  localparam int CFG_QUAD_BIT = 1;
  localparam int CFG_FREEZE_BIT = 0;

  // Suspend status field positions
  localparam int SUSP_ERASE_BIT = 1;
  localparam int SUSP_PROG_BIT = 0;

  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] SUSP_RESET = 8'h00;
  localparam logic [2:0] BP_VOL_RESET = 3'h7;
  localparam logic [2:0] BP_NV_RESET = 3'h0;
  localparam logic LOCK_RESET = 1'h0;

  // Array geometry: 25 address bits, smallest protected block is 2^19
  localparam int ADDR_W = 25;
  localparam logic [4:0] PROT_SHIFT_BASE = 5'h12;
  localparam logic [2:0] BP_NONE = 3'h0;
  localparam logic [2:0] BP_ALL = 3'h7;
  localparam logic UNIFORM_SECTORS = 1'h0;

  // Commands handed over by the serial command decoder
  typedef enum logic [2:0] {
    CMD_WRITE_ENABLE_SET,
    CMD_WRITE_ENABLE_CLEAR,
    CMD_WRITE_REGISTERS,
    CMD_PROGRAM,
    CMD_ERASE,
    CMD_SUSPEND,
    CMD_RESUME,
    CMD_CLEAR_STATUS
  } cmd_kind_type;

  typedef struct packed {
    cmd_kind_type kind;
    logic [7:0] status_data;
    logic [7:0] config_data;
    logic has_config;
    logic [ADDR_W-1:0] addr;
  } cmd_type;

  typedef struct packed {
    logic [7:0] primary_status;
    logic [7:0] device_configuration;
    logic [7:0] suspend_status;
  } reg_view_type;
endpackage : flash_regs_pkg
`default_nettype wire

// *** hdl/flash_status_config_regs.sv ***
// Purpose: Status, configuration and suspend registers of a serial flash
// Assumes: Commands arrive decoded on the serial clock; engine on sys_clk
// Notes: Commands cross domains by a toggle with no ack; register images by a toggle handshake
`default_nettype none
module flash_status_config_regs
  import flash_regs_pkg::*;
(
  // Core clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial link side, serial clock domain
  input wire logic link_clk,
  input wire logic cmd_valid,
  input wire cmd_type cmd_in,
  output var reg_view_type reg_view,
  // Write-protect pin, active low
  input wire logic write_protect_n,
  // Array engine, core domain
  input wire logic engine_busy,
  input wire logic program_error,
  input wire logic erase_error,
  output logic program_start,
  output logic erase_start,
  output logic suspend_req,
  output logic resume_req,
  output logic [ADDR_W-1:0] op_addr,
  // Configuration seen by the rest of the device
  output logic [2:0] protect_bits,
  output logic protect_origin,
  output logic param_at_top,
  output logic quad_mode,
  output logic [1:0] latency_code,
  output logic freeze
);
  typedef struct packed {
    logic wp_meta;
    logic wp_sync;
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic ack_meta;
    logic ack_sync;
    logic req;
    reg_view_type snap;
    logic lock;
    logic perr;
    logic eerr;
    logic [2:0] bp_nv;
    logic [2:0] bp_vol;
    logic [2:0] bp_eff;
    logic write_enable_latch;
    logic busy;
    logic [7:0] cfg;
    logic param_top;
    logic erase_susp;
    logic prog_susp;
    logic op_erase;
    logic [7:0] wr_timer;
    logic prog_start;
    logic erase_start;
    logic susp_req;
    logic res_req;
    logic [ADDR_W-1:0] addr;
  } core_type;

  typedef struct packed {
    logic tog;
    cmd_type hold;
    logic req_meta;
    logic req_sync;
    logic ack;
    reg_view_type view;
  } link_type;

  core_type s, next_s;
  link_type l, next_l;
  logic [1:0] sys_rst_pipe;
  logic [1:0] link_rst_pipe;
  logic sys_rst_n;
  logic link_rst_n;
  logic new_cmd;
  logic wrr_taken;
  logic wrr_refused;
  logic op_allowed;
  logic addr_protected;
  cmd_type cur;

  // Reset release through two flops per domain; assertion stays async
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_rst_pipe <= 2'h0;
    end else begin
      sys_rst_pipe <= {sys_rst_pipe[0], 1'h1};
    end
  end
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_rst_pipe <= 2'h0;
    end else begin
      link_rst_pipe <= {link_rst_pipe[0], 1'h1};
    end
  end
  assign sys_rst_n = sys_rst_pipe[1];
  assign link_rst_n = link_rst_pipe[1];

  // Protected range test: 2^(18+bp) bytes at the chosen end of the array
  function automatic logic in_range(input logic [2:0] bp,
                                    input logic bottom,
                                    input logic [ADDR_W-1:0] addr);
    logic [4:0] sh;
    logic [ADDR_W-1:0] hi;
    logic [ADDR_W-1:0] ones;
    sh = PROT_SHIFT_BASE + {2'h0, bp};
    hi = addr >> sh;
    ones = {ADDR_W{1'b1}} >> sh;
    if (bp == BP_NONE) begin
      in_range = 1'b0;
    end else if (bp == BP_ALL) begin
      in_range = 1'b1;
    end else if (bottom) begin
      in_range = (hi == '0);
    end else begin
      in_range = (hi == ones);
    end
  endfunction : in_range

  // Link domain: hold each command and toggle; pick up published images
  always_comb begin
    next_l = l;
    next_l.req_meta = s.req;
    next_l.req_sync = l.req_meta;
    if (cmd_valid) begin
      next_l.hold = cmd_in;
      next_l.tog = ~l.tog;
    end
    if (l.req_sync != l.ack) begin
      next_l.view = s.snap; // Stable until the ack returns
      next_l.ack = l.req_sync;
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // Decode helpers for the command that just crossed over
  assign cur = l.hold; // Host keeps the hold word still until it is taken
  assign new_cmd = s.tog_sync != s.tog_seen;
  assign wrr_refused = s.lock && !s.wp_sync;
  assign wrr_taken = new_cmd && cur.kind == CMD_WRITE_REGISTERS && s.write_enable_latch &&
                     !s.busy && !wrr_refused;
  assign op_allowed = s.write_enable_latch && !s.busy && !s.erase_susp && !s.prog_susp;
  assign addr_protected = in_range(s.bp_eff, s.cfg[CFG_ORIGIN_BIT],
                                   cur.addr);

  // Core domain next state
  always_comb begin
    next_s = s;
    next_s.wp_meta = write_protect_n;
    next_s.wp_sync = s.wp_meta;
    next_s.tog_meta = l.tog;
    next_s.tog_sync = s.tog_meta;
    next_s.tog_seen = s.tog_sync;
    next_s.ack_meta = l.ack;
    next_s.ack_sync = s.ack_meta;
    next_s.prog_start = 1'b0;
    next_s.erase_start = 1'b0;
    next_s.susp_req = 1'b0;
    next_s.res_req = 1'b0;
    if (s.wr_timer != 8'h00) begin
      next_s.wr_timer = s.wr_timer - 8'h01;
    end
    if (new_cmd) begin
      unique case (cur.kind)
        CMD_WRITE_ENABLE_SET: begin
          next_s.write_enable_latch = 1'b1;
        end
        CMD_WRITE_ENABLE_CLEAR: begin
          next_s.write_enable_latch = 1'b0;
        end
        CMD_WRITE_REGISTERS: begin
          if (wrr_taken) begin
            next_s.lock = cur.status_data[STAT_LOCK_BIT];
            if (!s.cfg[CFG_FREEZE_BIT]) begin
              if (s.cfg[CFG_VOLAT_BIT]) begin
                next_s.bp_vol = cur.status_data[STAT_BP_LSB +: 3];
              end else begin
                next_s.bp_nv = cur.status_data[STAT_BP_LSB +: 3];
              end
            end
            if (cur.has_config) begin
              next_s.cfg[CFG_LAT_LSB +: 2] =
                cur.config_data[CFG_LAT_LSB +: 2];
              next_s.cfg[CFG_QUAD_BIT] = cur.config_data[CFG_QUAD_BIT];
              // One-time bits only ever go from 0 to 1
              next_s.cfg[CFG_VOLAT_BIT] = s.cfg[CFG_VOLAT_BIT] |
                cur.config_data[CFG_VOLAT_BIT];
              if (!s.cfg[CFG_FREEZE_BIT]) begin
                next_s.cfg[CFG_ORIGIN_BIT] = s.cfg[CFG_ORIGIN_BIT] |
                  cur.config_data[CFG_ORIGIN_BIT];
                next_s.cfg[CFG_PARAM_BIT] = s.cfg[CFG_PARAM_BIT] |
                  cur.config_data[CFG_PARAM_BIT];
              end
              // Freeze only releases at reset, so a write cannot undo it
              next_s.cfg[CFG_FREEZE_BIT] = s.cfg[CFG_FREEZE_BIT] |
                cur.config_data[CFG_FREEZE_BIT];
            end
            next_s.wr_timer = REG_WRITE_CYCLES;
          end
        end
        CMD_PROGRAM, CMD_ERASE: begin
          if (op_allowed) begin
            if (addr_protected) begin
              if (cur.kind == CMD_ERASE) begin
                next_s.eerr = 1'b1;
              end else begin
                next_s.perr = 1'b1;
              end
            end else begin
              next_s.op_erase = cur.kind == CMD_ERASE;
              next_s.prog_start = cur.kind == CMD_PROGRAM;
              next_s.erase_start = cur.kind == CMD_ERASE;
              next_s.addr = cur.addr;
            end
          end
        end
        CMD_SUSPEND: begin
          if (engine_busy && !s.erase_susp && !s.prog_susp) begin
            next_s.erase_susp = s.op_erase;
            next_s.prog_susp = !s.op_erase;
            next_s.susp_req = 1'b1;
          end
        end
        CMD_RESUME: begin
          if (s.erase_susp || s.prog_susp) begin
            next_s.erase_susp = 1'b0;
            next_s.prog_susp = 1'b0;
            next_s.res_req = 1'b1;
          end
        end
        CMD_CLEAR_STATUS: begin
          next_s.perr = 1'b0;
          next_s.eerr = 1'b0;
        end
      endcase
    end
    // Engine errors last, so a set wins over a clear in the same cycle
    if (program_error) begin
      next_s.perr = 1'b1;
    end
    if (erase_error) begin
      next_s.eerr = 1'b1;
    end
    next_s.busy = next_s.wr_timer != 8'h00 || engine_busy ||
                  next_s.prog_start || next_s.erase_start;
    next_s.bp_eff = next_s.cfg[CFG_VOLAT_BIT] ? next_s.bp_vol :
                    next_s.bp_nv;
    next_s.param_top = next_s.cfg[CFG_PARAM_BIT] && !UNIFORM_SECTORS;
    // Publish a fresh image whenever the link side has taken the last
    if (s.ack_sync == s.req) begin
      next_s.snap.primary_status = {s.lock, s.perr, s.eerr, s.bp_eff,
                                    s.write_enable_latch, s.busy};
      next_s.snap.device_configuration = s.cfg;
      next_s.snap.suspend_status = {6'h00, s.erase_susp,
                                    s.prog_susp};
      next_s.req = ~s.req;
    end
  end

  always_ff @(posedge sys_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      s <= '0;
      s.lock <= LOCK_RESET;
      s.bp_vol <= BP_VOL_RESET;
      s.bp_nv <= BP_NV_RESET;
      s.bp_eff <= BP_NV_RESET;
      s.cfg <= CFG_RESET;
      s.snap.suspend_status <= SUSP_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state flops
  assign reg_view = l.view;
  assign program_start = s.prog_start;
  assign erase_start = s.erase_start;
  assign suspend_req = s.susp_req;
  assign resume_req = s.res_req;
  assign op_addr = s.addr;
  assign protect_bits = s.bp_eff;
  assign protect_origin = s.cfg[CFG_ORIGIN_BIT];
  assign param_at_top = s.param_top;
  assign quad_mode = s.cfg[CFG_QUAD_BIT];
  assign latency_code = s.cfg[CFG_LAT_LSB +: 2];
  assign freeze = s.cfg[CFG_FREEZE_BIT];

  // Checks on the core domain
  default clocking core_cb @(posedge sys_clk);
  endclocking
  default disable iff (!sys_rst_n);

  sequence wrr_locked_seq;
    new_cmd && cur.kind == CMD_WRITE_REGISTERS && wrr_refused;
  endsequence
  sequence op_no_latch_seq;
    new_cmd && (cur.kind == CMD_PROGRAM || cur.kind == CMD_ERASE) && !s.write_enable_latch;
  endsequence

  a_locked_write_ignored: assert property (
    wrr_locked_seq |=> $stable(s.cfg) && $stable(s.lock) &&
      $stable(s.bp_nv) && $stable(s.bp_vol) && s.wr_timer != REG_WRITE_CYCLES)
    else $error("locked register write changed state");
  a_no_latch_no_op: assert property (
    op_no_latch_seq |=> !s.prog_start && !s.erase_start)
    else $error("program or erase started without write enable");
  a_latch_wrr_stable: assert property (
    wrr_taken |=> $stable(s.write_enable_latch))
    else $error("register write altered the write-enable latch");
  a_busy_after_write: assert property (
    wrr_taken |=> s.busy [*8])
    else $error("busy flag not held after register write");
  a_otp_never_falls: assert property (
    $fell(s.cfg[CFG_ORIGIN_BIT]) == 1'b0 && !$fell(s.cfg[CFG_VOLAT_BIT]))
    else $error("one-time configuration bit was cleared");
  a_freeze_keeps_bp: assert property (
    s.cfg[CFG_FREEZE_BIT] |=> $stable(s.bp_nv) && $stable(s.bp_vol))
    else $error("protect bits changed while frozen");
  a_perr_sets: assert property (
    program_error |=> s.perr ##1 (s.snap.primary_status[STAT_PERR_BIT] ||
                                  $past(s.ack_sync != s.req)))
    else $error("program error did not set its flag");
  a_suspend_exclusive: assert property (
    !(s.erase_susp && s.prog_susp))
    else $error("erase and program suspended together");
  a_suspend_reserved: assert property (
    s.snap.suspend_status[7:2] == 6'h00)
    else $error("reserved suspend bits not zero");
  a_prog_susp_cause: assert property (
    $rose(s.prog_susp) |-> $past(new_cmd) && !s.op_erase)
    else $error("program suspend flag rose without a suspend");
  a_busy_tracks_engine: assert property (
    engine_busy |=> s.busy)
    else $error("busy flag low while the engine runs");
endmodule : flash_status_config_regs
`default_nettype wire

// *** verification/host_link_model.sv ***
// Purpose: Host controller model driving the serial command link
// Assumes: Link clock of 160 ns that stands low between frames
// Notes: Idle frames are clocked only to fetch the register image
`default_nettype none
module host_link_model
  import flash_regs_pkg::*;
(
  // Link towards the bank
  output var logic link_clk,
  output var logic cmd_valid,
  output var cmd_type cmd_in,
  // Register image back from the bank
  input wire reg_view_type reg_view
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle link, clock parked low
  initial begin
    link_clk = 1'b0;
    cmd_valid = 1'b0;
    cmd_in = '0;
  end

  // One period of the link clock
  task automatic pulse();
    #80 link_clk = 1'b1;
    #80 link_clk = 1'b0;
  endtask : pulse

  // One command edge, then a spare period so the hold word stays put
  task automatic send(input cmd_type c);
    cmd_valid = 1'b1;
    cmd_in = c;
    pulse();
    cmd_valid = 1'b0;
    pulse();
    cmd_in = ~c; // Released word is garbage, not the last value
  endtask : send

  // Clock an idle frame so the image handshake can complete
  task automatic read_view(input int n, output reg_view_type v);
    repeat (n) pulse();
    v = reg_view;
  endtask : read_view
endmodule : host_link_model
`default_nettype wire

// *** verification/test_flash_status_config_regs.sv ***
// Purpose: Self-checking bench of the flash status and config bank
// Assumes: Commands reach the bank only through the host link model
// Notes: An integer model of the registers is compared at every view
`default_nettype none
module test_flash_status_config_regs
  import flash_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b1; // Pulled low at time 0 so both domains see an edge
  logic write_protect_n = 1'b1;
  logic engine_busy = 1'b0;
  logic program_error = 1'b0;
  logic erase_error = 1'b0;
  logic link_clk, cmd_valid, program_start, erase_start;
  logic suspend_req, resume_req, protect_origin, param_at_top;
  logic quad_mode, freeze;
  logic [ADDR_W-1:0] op_addr, a;
  logic [2:0] protect_bits;
  logic [1:0] latency_code;
  logic [31:0] r;
  cmd_type cmd_in;
  reg_view_type reg_view, v;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_cycles = 0;
  int n_prog = 0;
  int n_erase = 0;
  int seed = 32'hda3650d4;
  // Register model
  int lock, perr, eerr, bp, write_enable_latch, lat, origin, param, quad, frz, susp;
  int last, exp_prog, exp_erase;
  int vol, bpe;
  int bpv = BP_VOL_RESET; // Volatile protect copy powers up all set

  flash_status_config_regs dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
    .cmd_valid(cmd_valid), .cmd_in(cmd_in), .reg_view(reg_view),
    .write_protect_n(write_protect_n), .engine_busy(engine_busy),
    .program_error(program_error), .erase_error(erase_error),
    .program_start(program_start), .erase_start(erase_start),
    .suspend_req(suspend_req), .resume_req(resume_req),
    .op_addr(op_addr), .protect_bits(protect_bits),
    .protect_origin(protect_origin), .param_at_top(param_at_top),
    .quad_mode(quad_mode), .latency_code(latency_code), .freeze(freeze)
  );

  host_link_model host (
    .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_in(cmd_in),
    .reg_view(reg_view)
  );

  // Core clock
  always #5 sys_clk = ~sys_clk;

  // Cycle ceiling and engine start counters
  always @(posedge sys_clk) begin
    n_cycles <= n_cycles + 1;
    if (program_start === 1'b1)
      n_prog <= n_prog + 1;
    if (erase_start === 1'b1)
      n_erase <= n_erase + 1;
    if (n_cycles == 30000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Send one command and advance the model the way the bank should
  task automatic cmd(input cmd_kind_type k, input logic [7:0] sd,
                     input logic [7:0] cd);
    host.send('{k, sd, cd, 1'b1, a});
    case (k)
      CMD_WRITE_ENABLE_SET: write_enable_latch = 1;
      CMD_WRITE_ENABLE_CLEAR: write_enable_latch = 0;
      CMD_CLEAR_STATUS: begin
        perr = 0;
        eerr = 0;
      end
      CMD_SUSPEND: susp = engine_busy ? last : 0;
      CMD_RESUME: susp = 0;
      CMD_WRITE_REGISTERS: begin
        if (write_enable_latch == 1 && !(lock == 1 && !write_protect_n)) begin
          lock = sd[7];
          if (frz == 0) begin
            if (vol == 1)
              bpv = sd[4:2];
            else
              bp = sd[4:2];
            origin |= cd[5];
            param |= cd[2];
          end
          vol |= cd[3];
          lat = cd[7:6];
          quad = cd[1];
          frz |= cd[0];
        end
      end
      default: begin
        if (write_enable_latch == 1 && !engine_busy && susp == 0) begin
          last = (k == CMD_PROGRAM) ? 1 : 2;
          if (bpe == 7 && last == 1)
            perr = 1;
          else if (bpe == 7)
            eerr = 1;
          else if (last == 1)
            exp_prog++;
          else
            exp_erase++;
        end
      end
    endcase
    // Effective protect bits follow the volatility choice
    bpe = (vol == 1) ? bpv : bp;
  endtask : cmd

  // Fetch the image after n link periods and compare all views
  task automatic view(input int n, input int b);
    host.read_view(n, v);
    check(v.primary_status, {lock[0], perr[0], eerr[0], bpe[2:0],
          write_enable_latch[0], b[0]});
    check(v.device_configuration, {lat[1:0], origin[0], 1'b0, vol[0],
          param[0], quad[0], frz[0]});
    check(v.suspend_status, {6'h00, susp[1:0]});
    check({protect_bits, protect_origin, param_at_top, quad_mode,
           latency_code, freeze}, {bpe[2:0], origin[0], param[0],
           quad[0], lat[1:0], frz[0]});
    check(n_prog, exp_prog);
    check(n_erase, exp_erase);
  endtask : view

  // Main sequence; reset is held for two core cycles at the start
  initial begin
    rst_n <= 1'b0;
    r = $random(seed);
    a = r[ADDR_W-1:0];
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    view(8, 0);
    cmd(CMD_WRITE_REGISTERS, 8'h9c, 8'hc2);
    view(8, 0);
    cmd(CMD_WRITE_ENABLE_SET, 8'h00, 8'h00);
    view(8, 0);
    cmd(CMD_WRITE_REGISTERS, 8'h1c, {r[1:0], 6'h02});
    view(5, 1);
    view(8, 0);
    cmd(CMD_PROGRAM, 8'h00, 8'h00);
    view(8, 0);
    cmd(CMD_ERASE, 8'h00, 8'h00);
    view(8, 0);
    cmd(CMD_CLEAR_STATUS, 8'h00, 8'h00);
    @(posedge sys_clk) program_error <= 1'b1;
    @(posedge sys_clk) program_error <= 1'b0;
    perr = 1;
    view(8, 0);
    cmd(CMD_CLEAR_STATUS, 8'h00, 8'h00);
    @(posedge sys_clk) erase_error <= 1'b1;
    @(posedge sys_clk) erase_error <= 1'b0;
    eerr = 1;
    view(8, 0);
    cmd(CMD_WRITE_REGISTERS, 8'h80, {r[3:2], 6'h24});
    view(5, 1);
    view(8, 0);
    // Locked with the pin low: the write must vanish
    @(posedge sys_clk) write_protect_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cmd(CMD_WRITE_REGISTERS, 8'h14, 8'h00);
    view(8, 0);
    @(posedge sys_clk) write_protect_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cmd(CMD_WRITE_REGISTERS, 8'h00, {r[3:2], 6'h24});
    view(5, 1);
    view(8, 0);
    // Program then erase, each suspended and resumed
    r = $random(seed);
    a = r[ADDR_W-1:0];
    for (int i = 0; i < 2; i++) begin
      cmd(i == 0 ? CMD_PROGRAM : CMD_ERASE, 8'h00, 8'h00);
      @(posedge sys_clk) engine_busy <= 1'b1;
      view(8, 1);
      check(op_addr, a);
      cmd(CMD_SUSPEND, 8'h00, 8'h00);
      view(8, 1);
      cmd(CMD_RESUME, 8'h00, 8'h00);
      view(8, 1);
      @(posedge sys_clk) engine_busy <= 1'b0;
    end
    cmd(CMD_WRITE_ENABLE_CLEAR, 8'h00, 8'h00);
    cmd(CMD_PROGRAM, 8'h00, 8'h00);
    view(8, 0);
    // Freeze keeps protection but not the latency code
    cmd(CMD_WRITE_ENABLE_SET, 8'h00, 8'h00);
    cmd(CMD_WRITE_REGISTERS, 8'h08, 8'h01);
    view(5, 1);
    view(8, 0);
    cmd(CMD_WRITE_REGISTERS, 8'h0c, 8'h41);
    view(5, 1);
    view(8, 0);
    // Volatile protect bits take over, still at their all-set power-up value
    cmd(CMD_WRITE_REGISTERS, 8'h00, 8'h48);
    view(5, 1);
    view(8, 0);
    cmd(CMD_PROGRAM, 8'h00, 8'h00);
    view(8, 0);
    stop_test();
  end
endmodule : test_flash_status_config_regs
`default_nettype wire
